// ==== src/bsel_bay_status.sv ====
// bay status, presence mirror and sticky event logic behind AXI4-Lite
//
// Overview of operation
// - state field shows the real machine state, not the last request
// - only a hardware event moves the bay into the empty state
// - state codes 000..101: empty,inserted,enabled,remreq,remok,debounce
// - button press with a device present sets sticky bit 3
// - button release sets nothing and raises no event
// - interrupt when an event flag and its enable are both set
// - event flags clear only on a written one; zero leaves them
// - removal flag value after reset with device present is free
// - without a button the removal flag reads zero, writes ignored
// - any presence pin change sets sticky bit 2
// - on insertion bit 2 waits for the settle timer to expire
// - settle interval in half-second steps, 0.5 s up to 8.0 s
// - bit 1 is the inverse of the firewire presence pin
// - bit 0 is the inverse of the usb presence pin
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module bsel_bay_status import bsel_pkg::*; #(
  parameter bit HAS_BUTTON = 1'b1,
  parameter logic [2:0] FORM_FACTOR = 3'h0,
  parameter int unsigned STEP_CYCLES = SETTLE_STEP_CYCLES
) (
  input wire logic core_clk, // controller clock
  input wire logic rst_n, // async reset, active low
  input wire logic firewire_present_pin_n, // firewire presence
  input wire logic usb_present_pin_n, // usb presence
  input wire logic remove_button_n, // removal button, low = pressed
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic irq // level interrupt
);
  logic [2:0] pins_sync;
  logic [2:0] pins_prev_reg;
  logic fw_present;
  logic usb_present;
  logic any_present;
  logic press_rise;
  logic insert_edge;
  logic remove_edge;
  logic settle_expired;
  bsel_state_type state_reg;
  logic [2:0] state_code;
  logic removal_request_flag;
  logic presence_change_flag;
  logic [31:0] ctl_reg;
  logic [SETTLE_W-1:0] insertion_settle_interval;
  logic [31:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic wr_fire;
  logic [31:0] wr_addr;
  logic wr_ok;
  logic [31:0] clr_bits;
  logic req_write;
  logic [2:0] req_code;

  bsel_sync3 #(
    .WIDTH(3),
    .RESET_VAL(3'b111)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({remove_button_n, firewire_present_pin_n, usb_present_pin_n}),
    .sync_out(pins_sync)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev_reg <= 3'b111;
    end else begin
      pins_prev_reg <= pins_sync;
    end
  end

  assign fw_present = !pins_sync[1];
  assign usb_present = !pins_sync[0];
  assign any_present = fw_present || usb_present;
  assign press_rise = HAS_BUTTON && pins_prev_reg[2] && !pins_sync[2];
  assign insert_edge = |(pins_prev_reg[1:0] & ~pins_sync[1:0]);
  assign remove_edge = |(~pins_prev_reg[1:0] & pins_sync[1:0]);

  bsel_settle_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(insert_edge),
    .abort(!any_present),
    .interval(insertion_settle_interval),
    .expired(settle_expired)
  );

  // write channel: address and data taken in either order
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_addr = {aw_addr_reg[31:2], 2'b00};
  assign wr_ok = (wr_addr == ADDR_STATUS) || (wr_addr == ADDR_CONTROL) ||
                 (wr_addr == ADDR_CONFIG) || (wr_addr == ADDR_CLEAR);
  assign req_write = wr_fire && (wr_addr == ADDR_CONTROL) && w_strb_reg[0];
  assign req_code = w_data_reg[CTL_REQ_LSB +: 3];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 32'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_reg && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control and settle configuration; low byte holds every field
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= CTL_RESET;
      insertion_settle_interval <= CFG_RESET;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (wr_addr == ADDR_CONTROL) begin
        ctl_reg <= w_data_reg & CTL_MASK;
      end
      if (wr_addr == ADDR_CONFIG) begin
        insertion_settle_interval <= w_data_reg[SETTLE_W-1:0];
      end
    end
  end

  // one-to-clear through the status word or the clear register
  assign clr_bits = (wr_fire && w_strb_reg[0] &&
                     (wr_addr == ADDR_STATUS || wr_addr == ADDR_CLEAR)) ?
                    w_data_reg : 32'h0;

  // bay state machine; software requests that do not fit are dropped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BAY_EMPTY;
    end else begin
      case (state_reg)
        BAY_EMPTY: begin
          if (any_present) begin
            state_reg <= BAY_DEBOUNCE;
          end
        end
        BAY_DEBOUNCE: begin
          if (settle_expired) begin
            state_reg <= BAY_INSERTED;
          end
        end
        BAY_INSERTED: begin
          if (req_write && req_code == ST_ENABLED) begin
            state_reg <= BAY_ENABLED;
          end
        end
        BAY_ENABLED: begin
          if (press_rise) begin
            state_reg <= BAY_REM_REQ;
          end else if (req_write && req_code == ST_REM_OK) begin
            state_reg <= BAY_REM_OK;
          end
        end
        BAY_REM_REQ: begin
          if (req_write && req_code == ST_REM_OK) begin
            state_reg <= BAY_REM_OK;
          end else if (req_write && req_code == ST_ENABLED) begin
            state_reg <= BAY_ENABLED;
          end
        end
        BAY_REM_OK: begin
          if (req_write && req_code == ST_ENABLED) begin
            state_reg <= BAY_ENABLED;
          end
        end
        default: begin
          state_reg <= BAY_EMPTY;
        end
      endcase
      // empty only on loss of presence
      if (!any_present) begin
        state_reg <= BAY_EMPTY;
      end
    end
  end

  always_comb begin
    case (state_reg)
      BAY_EMPTY: state_code = ST_EMPTY;
      BAY_INSERTED: state_code = ST_INSERTED;
      BAY_ENABLED: state_code = ST_ENABLED;
      BAY_REM_REQ: state_code = ST_REM_REQ;
      BAY_REM_OK: state_code = ST_REM_OK;
      BAY_DEBOUNCE: state_code = ST_DEBOUNCE;
      default: state_code = ST_EMPTY;
    endcase
  end

  // cleared at reset, a present device does not set it
  // a set in the same cycle beats the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      removal_request_flag <= 1'b0;
    end else if (!HAS_BUTTON) begin
      removal_request_flag <= 1'b0;
    end else if (press_rise && any_present) begin
      removal_request_flag <= 1'b1;
    end else if (clr_bits[ST_REMREQ_BIT]) begin
      removal_request_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      presence_change_flag <= 1'b0;
    end else if (remove_edge || settle_expired) begin
      // removal at once, insertion after settling
      presence_change_flag <= 1'b1;
    end else if (clr_bits[ST_CHG_BIT]) begin
      presence_change_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (removal_request_flag && ctl_reg[ST_REMREQ_BIT]) ||
             (presence_change_flag && ctl_reg[ST_CHG_BIT]);
    end
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= 32'h0;
        case ({s_axi_araddr[31:2], 2'b00})
          ADDR_STATUS: begin
            s_axi_rdata[ST_FF_LSB +: 3] <= FORM_FACTOR;
            s_axi_rdata[ST_LOCK_BIT] <= 1'b0;
            s_axi_rdata[ST_STATE_LSB +: 3] <= state_code;
            s_axi_rdata[ST_REMREQ_BIT] <= removal_request_flag;
            s_axi_rdata[ST_CHG_BIT] <= presence_change_flag;
            s_axi_rdata[ST_FW_BIT] <= fw_present;
            s_axi_rdata[ST_USB_BIT] <= usb_present;
          end
          ADDR_CONTROL: s_axi_rdata <= ctl_reg;
          ADDR_CONFIG: s_axi_rdata[SETTLE_W-1:0] <= insertion_settle_interval;
          ADDR_CLEAR: s_axi_rdata <= 32'h0;
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  state_code_a: assert property (
    $onehot(state_reg) && state_code <= ST_DEBOUNCE)
    else $error("bay state code out of range");
  empty_hw_a: assert property (
    $changed(state_reg) && state_reg == BAY_EMPTY |-> !any_present)
    else $error("empty state entered while a device is present");
  remreq_set_a: assert property (
    press_rise && any_present |=> removal_request_flag)
    else $error("press with device present did not set flag");
  release_a: assert property (
    $rose(removal_request_flag) |-> $past(press_rise))
    else $error("removal flag rose without a press");
  irq_a: assert property (
    presence_change_flag && ctl_reg[ST_CHG_BIT] && !clr_bits[ST_CHG_BIT]
    |=> irq)
    else $error("enabled change event gave no interrupt");
  w1c_hold_a: assert property (
    presence_change_flag && !clr_bits[ST_CHG_BIT] |=> presence_change_flag)
    else $error("change flag lost without a written one");
  no_button_a: assert property (
    !HAS_BUTTON |-> !removal_request_flag)
    else $error("removal flag set without a button");
  insert_delay_a: assert property (
    $rose(presence_change_flag) |-> $past(remove_edge || settle_expired))
    else $error("change flag set before settling");
  presence_a: assert property (
    s_axi_arvalid && s_axi_arready &&
    {s_axi_araddr[31:2], 2'b00} == ADDR_STATUS
    |=> s_axi_rdata[ST_USB_BIT] == $past(usb_present))
    else $error("usb presence bit not inverted pin");

  insert_c: cover property (insert_edge ##[1:1000] settle_expired);
  press_c: cover property (press_rise && any_present);
  irq_c: cover property ($rose(irq));
endmodule // bsel_bay_status

// ==== include/bsel_pkg.sv ====
// constants and types shared by the bay status and event logic
package bsel_pkg;
  // clock rate and the settle-interval step derived from it
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SETTLE_STEP_MS = 500;
  localparam int unsigned SETTLE_STEP_CYCLES = CLK_HZ / 1000 * SETTLE_STEP_MS;
  localparam int SETTLE_W = 4;

  // register byte addresses
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
  localparam logic [31:0] ADDR_CONTROL = 32'h0000_0004;
  localparam logic [31:0] ADDR_CONFIG = 32'h0000_0008;
  localparam logic [31:0] ADDR_CLEAR = 32'h0000_000c;

  // bay_status field positions
  localparam int ST_USB_BIT = 0;
  localparam int ST_FW_BIT = 1;
  localparam int ST_CHG_BIT = 2;
  localparam int ST_REMREQ_BIT = 3;
  localparam int ST_STATE_LSB = 4;
  localparam int ST_LOCK_BIT = 7;
  localparam int ST_FF_LSB = 8;

  // bay_control_enable_reg: enables share the status layout
  localparam int CTL_REQ_LSB = 4;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_MASK = 32'h0000_007c;
  localparam logic [SETTLE_W-1:0] CFG_RESET = 4'h0;

  // bay state field codes
  localparam logic [2:0] ST_EMPTY = 3'h0;
  localparam logic [2:0] ST_INSERTED = 3'h1;
  localparam logic [2:0] ST_ENABLED = 3'h2;
  localparam logic [2:0] ST_REM_REQ = 3'h3;
  localparam logic [2:0] ST_REM_OK = 3'h4;
  localparam logic [2:0] ST_DEBOUNCE = 3'h5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    BAY_EMPTY = 6'b000001,
    BAY_INSERTED = 6'b000010,
    BAY_ENABLED = 6'b000100,
    BAY_REM_REQ = 6'b001000,
    BAY_REM_OK = 6'b010000,
    BAY_DEBOUNCE = 6'b100000
  } bsel_state_type;
endpackage

// ==== src/bsel_sync3.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module bsel_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk, // controller clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out // filtered level
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= RESET_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // bsel_sync3

// ==== src/bsel_settle_timer.sv ====
// insertion settle timer counted in half-second steps
`timescale 1ns/1ps
module bsel_settle_timer import bsel_pkg::*; #(
  parameter int unsigned STEP_CYCLES = SETTLE_STEP_CYCLES
) (
  input wire logic core_clk, // controller clock
  input wire logic rst_n, // async reset, active low
  input wire logic start, // restart the interval
  input wire logic abort, // cancel a running interval
  input wire logic [SETTLE_W-1:0] interval, // steps minus one
  output logic expired // one-cycle pulse at the end
);
  logic [31:0] pre_reg;
  logic [SETTLE_W-1:0] step_reg;
  logic busy_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 32'h0;
      step_reg <= '0;
      busy_reg <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        busy_reg <= 1'b1;
        pre_reg <= 32'(STEP_CYCLES - 1);
        step_reg <= interval;
      end else if (abort) begin
        busy_reg <= 1'b0;
      end else if (busy_reg) begin
        if (pre_reg != 32'h0) begin
          pre_reg <= pre_reg - 32'h1;
        end else if (step_reg == '0) begin
          busy_reg <= 1'b0;
          expired <= 1'b1;
        end else begin
          step_reg <= step_reg - SETTLE_W'(1);
          pre_reg <= 32'(STEP_CYCLES - 1);
        end
      end
    end
  end
endmodule // bsel_settle_timer

// ==== test/bsel_bay_model.sv ====
// model of the bay device: presence pins and removal button
`timescale 1ns/1ps
module bsel_bay_model (
  input wire logic usb_in, // usb device seated
  input wire logic fw_in, // firewire device seated
  input wire logic press, // user holds the button
  output logic usb_present_pin_n, // low while usb seated
  output logic firewire_present_pin_n, // low while firewire seated
  output logic remove_button_n // low while pressed
);
  // pins idle high through the bay pull-ups, so an empty bay reads high
  assign usb_present_pin_n = ~usb_in;
  assign firewire_present_pin_n = ~fw_in;
  assign remove_button_n = ~press;
endmodule // bsel_bay_model

// ==== test/tb_top.sv ====
// register-level bench for the bay status and event logic
`timescale 1ns/1ps
module tb_top;
  import bsel_pkg::*;
  // short settle step keeps the run brief; one step is 20 cycles
  localparam int unsigned STEPS = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic usb_in = 1'b0;
  logic fw_in = 1'b0;
  logic press = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rdata_nb;
  logic usb_pin_n, fw_pin_n, btn_n;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  always #50 core_clk = ~core_clk;

  bsel_bay_model bay (.usb_in(usb_in), .fw_in(fw_in), .press(press),
    .usb_present_pin_n(usb_pin_n), .firewire_present_pin_n(fw_pin_n),
    .remove_button_n(btn_n));

  bsel_bay_status #(.STEP_CYCLES(STEPS)) DUT (.core_clk(core_clk),
    .rst_n(rst_n), .firewire_present_pin_n(fw_pin_n),
    .usb_present_pin_n(usb_pin_n), .remove_button_n(btn_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));

  // twin without a button on the same pins and bus; its handshakes march
  // in step with the main instance, so only its read data is looked at
  bsel_bay_status #(.HAS_BUTTON(1'b0), .STEP_CYCLES(STEPS)) no_btn (
    .core_clk(core_clk), .rst_n(rst_n), .firewire_present_pin_n(fw_pin_n),
    .usb_present_pin_n(usb_pin_n), .remove_button_n(btn_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(rdata_nb), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(rready), .irq());

  function automatic logic [31:0] st(input logic [2:0] s,
      input logic r, input logic c, input logic f, input logic u);
    st = {21'h0, 3'h0, 1'b0, s, r, c, f, u};
  endfunction

  task automatic print_verdict();
    $display("mismatches %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
      input logic [1:0] er);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bready && bvalid));
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rready && rvalid));
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  task automatic rdc(input string n, input logic [31:0] a,
      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, e, d);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  // a hung handshake lands here and still gives a verdict
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    tick(8);
    rst_n <= 1'b1;
    tick(10);
    rdc("status reset", ADDR_STATUS, st(3'h0, 0, 0, 0, 0));
    rdc("control reset", ADDR_CONTROL, CTL_RESET);
    rdc("config reset", ADDR_CONFIG, {28'h0, CFG_RESET});
    rd(32'h0000_0010, d, r);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(32'h0000_0010, 32'hffff_ffff, RESP_SLVERR);
    // usb insertion: presence shows at once, change waits for the timer
    usb_in <= 1'b1;
    tick(10);
    rdc("usb settling", ADDR_STATUS, st(3'h5, 0, 0, 0, 1));
    tick(30);
    rdc("usb settled", ADDR_STATUS, st(3'h1, 0, 1, 0, 1));
    wr(ADDR_CONTROL, 32'h0000_0004, RESP_OKAY);
    tick(3);
    chk("irq change", 32'h1, {31'h0, irq});
    wr(ADDR_CLEAR, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    rdc("zero keeps flag", ADDR_STATUS, st(3'h1, 0, 1, 0, 1));
    wr(ADDR_CLEAR, 32'h0000_0004, RESP_OKAY);
    tick(3);
    rdc("one clears flag", ADDR_STATUS, st(3'h1, 0, 0, 0, 1));
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(ADDR_CONTROL, 32'h0000_0024, RESP_OKAY);
    rdc("enabled", ADDR_STATUS, st(3'h2, 0, 0, 0, 1));
    wr(ADDR_CONTROL, 32'h0000_0004, RESP_OKAY);
    rdc("no soft empty", ADDR_STATUS, st(3'h2, 0, 0, 0, 1));
    wr(ADDR_CONTROL, 32'h0000_0074, RESP_OKAY);
    rdc("bad request", ADDR_STATUS, st(3'h2, 0, 0, 0, 1));
    // button press with a device present, flag cleared while held
    wr(ADDR_CONTROL, 32'h0000_000c, RESP_OKAY);
    press <= 1'b1;
    tick(10);
    rdc("press", ADDR_STATUS, st(3'h3, 1, 0, 0, 1));
    chk("no button flag", 32'h0, {31'h0, rdata_nb[ST_REMREQ_BIT]});
    chk("irq remreq", 32'h1, {31'h0, irq});
    wr(ADDR_STATUS, 32'h0000_0008, RESP_OKAY);
    press <= 1'b0;
    tick(10);
    rdc("release", ADDR_STATUS, st(3'h3, 0, 0, 0, 1));
    chk("irq after release", 32'h0, {31'h0, irq});
    wr(ADDR_CONTROL, 32'h0000_004c, RESP_OKAY);
    rdc("allowed", ADDR_STATUS, st(3'h4, 0, 0, 0, 1));
    // removal sets the change flag without waiting
    usb_in <= 1'b0;
    tick(10);
    rdc("removed", ADDR_STATUS, st(3'h0, 0, 1, 0, 0));
    chk("irq removal", 32'h1, {31'h0, irq});
    wr(ADDR_CLEAR, 32'h0000_0004, RESP_OKAY);
    press <= 1'b1;
    tick(10);
    rdc("press empty", ADDR_STATUS, st(3'h0, 0, 0, 0, 0));
    press <= 1'b0;
    // two settle steps: 40 cycles before the change flag
    wr(ADDR_CONFIG, 32'h0000_0001, RESP_OKAY);
    rdc("config", ADDR_CONFIG, 32'h0000_0001);
    fw_in <= 1'b1;
    tick(30);
    rdc("fw settling", ADDR_STATUS, st(3'h5, 0, 0, 1, 0));
    tick(30);
    rdc("fw settled", ADDR_STATUS, st(3'h1, 0, 1, 1, 0));
    print_verdict();
  end
endmodule // tb_top
